// [hw/svd_core.sv]
/*
  Receive-side core of a two-port serial video deserializer: link clock
  lock, symbol buffer, seven-bit display lanes, port-steered settings,
  back-channel frames and I2C bridge drive.
  Assumes link pins are asynchronous and sampled here; config port is on
  clk_in.
*/
`timescale 1ns/1ps
`include "svd_params.svh"
module svd_core
  import svd_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        power_down_n_in,
  // serial link
  input  wire logic        link_clk_in,
  input  wire svd_sym_t    link_symbol_in,
  output logic             link_ready_out,
  // straps
  input  wire logic        mode_strap_one_in,
  input  wire logic        dual_output_in,
  // configuration port
  input  wire logic        cfg_wr_in,
  input  wire logic        cfg_rd_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [7:0]  cfg_wdata_in,
  output logic      [7:0]  cfg_rdata_out,
  // display lanes
  output logic      [7:0]  lvds_data_out,
  output logic      [1:0]  lvds_clk_out,
  output logic             lvds_oe_out,
  // lock status
  output logic             lock_out,
  output logic             lock_oe_out,
  // back channel and bridge
  input  wire logic [3:0]  gpio_in,
  input  wire logic        i2c_sda_in,
  input  wire logic        local_master_busy_in,
  output logic             i2c_sda_out,
  output logic             i2c_sda_oe_out,
  output logic             back_chan_out
);
  // pin synchronisers
  logic     lclk_s1, lclk_s2, lclk_s3;
  svd_sym_t sym_s1, sym_s2;
  logic [9:0] pin_s1, pin_s2;
  logic       pdn_s1, pdn_s2;
  logic       rst;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      lclk_s1 <= 1'b0;
      lclk_s2 <= 1'b0;
      lclk_s3 <= 1'b0;
      sym_s1  <= '0;
      sym_s2  <= '0;
      pin_s1  <= '0;
      pin_s2  <= '0;
      pdn_s1  <= 1'b0;
      pdn_s2  <= 1'b0;
    end else begin
      lclk_s1 <= link_clk_in;
      lclk_s2 <= lclk_s1;
      lclk_s3 <= lclk_s2;
      sym_s1  <= link_symbol_in;
      sym_s2  <= sym_s1;
      pin_s1  <= {local_master_busy_in, i2c_sda_in, gpio_in,
                  dual_output_in, mode_strap_one_in, 2'h0};
      pin_s2  <= pin_s1;
      pdn_s1  <= power_down_n_in;
      pdn_s2  <= pdn_s1;
    end
  end

  assign rst = sys_rst_in | ~pdn_s2;

  logic lclk_rise;
  logic busy_s, sda_s;
  logic [3:0] gpio_s;
  assign lclk_rise = lclk_s2 & ~lclk_s3;
  assign busy_s    = pin_s2[9];
  assign sda_s     = pin_s2[8];
  assign gpio_s    = pin_s2[7:4];

  // straps caught once after reset release
  logic strap_taken, strap_fast, dual;
  always_ff @(posedge clk_in) begin
    if (rst) begin
      strap_taken <= 1'b0;
      strap_fast  <= 1'b0;
      dual        <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      strap_fast  <= pin_s2[2];
      dual        <= pin_s2[3];
    end
  end

  // lock tracking
  svd_lock_state_t lock_st, next_lock_st;
  logic [4:0] edge_cnt, next_edge_cnt;
  logic [7:0] gap_cnt,  next_gap_cnt;
  logic       gap_expired, locked;

  assign gap_expired = (gap_cnt == 8'(`SVD_LOSS_CYCLES));
  assign locked      = (lock_st == SVD_LOCKED);

  always_comb begin
    next_lock_st  = lock_st;
    next_edge_cnt = edge_cnt;
    next_gap_cnt  = gap_cnt;
    if (lclk_rise) begin
      next_gap_cnt = 8'h00;
    end else if (!gap_expired) begin
      next_gap_cnt = gap_cnt + 8'h01;
    end
    case (lock_st)
      SVD_LOSS: begin
        if (lclk_rise) begin
          next_lock_st  = SVD_ACQ;
          next_edge_cnt = 5'h01;
        end
      end
      SVD_ACQ: begin
        if (gap_expired) begin
          next_lock_st = SVD_LOSS;
        end else if (lclk_rise) begin
          if (edge_cnt == 5'(`SVD_LOCK_EDGES - 1)) begin
            next_lock_st = SVD_LOCKED;
          end else begin
            next_edge_cnt = edge_cnt + 5'h01;
          end
        end
      end
      SVD_LOCKED: begin
        if (gap_expired) begin
          next_lock_st = SVD_LOSS;
        end
      end
      default: next_lock_st = SVD_LOSS;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      lock_st  <= SVD_LOSS;
      edge_cnt <= 5'h00;
      gap_cnt  <= 8'h00;
    end else begin
      lock_st  <= next_lock_st;
      edge_cnt <= next_edge_cnt;
      gap_cnt  <= next_gap_cnt;
    end
  end

  // symbol buffer
  svd_stream_if #(.W(`SVD_SYM_W)) fin ();
  svd_stream_if #(.W(`SVD_SYM_W)) fout ();
  assign fin.valid = lclk_rise & locked;
  assign fin.data  = sym_s2;

  svd_fifo #(.W(`SVD_SYM_W), .DEPTH(`SVD_FIFO_DEPTH)) u_fifo (
    .clk_in     (clk_in),
    .sys_rst_in (rst),
    .in_s       (fin),
    .out_s      (fout)
  );

  // configuration registers
  logic [7:0] ctrl, next_ctrl;
  logic [1:0] psel, next_psel;
  logic [7:0] pcfg [2];
  logic [7:0] next_pcfg [2];
  logic [7:0] next_rdata;
  logic       ovf, next_ovf;
  logic       out_en, sleep_sel, osc_en;

  assign out_en    = ctrl[`SVD_CTRL_OE_BIT];
  assign sleep_sel = ctrl[`SVD_CTRL_SLEEP_BIT];
  assign osc_en    = ctrl[`SVD_CTRL_OSC_BIT];

  always_comb begin
    next_ctrl  = ctrl;
    next_psel  = psel;
    next_pcfg  = pcfg;
    next_rdata = cfg_rdata_out;
    next_ovf   = ovf;
    if (cfg_wr_in) begin
      case (cfg_addr_in)
        `SVD_ADDR_CTRL:     next_ctrl = cfg_wdata_in;
        `SVD_ADDR_PORT_SEL: next_psel = cfg_wdata_in[1:0];
        `SVD_ADDR_PORT_CFG: begin
          for (int p = 0; p < 2; p++) begin
            if (psel[p]) begin
              next_pcfg[p] = cfg_wdata_in;
            end
          end
        end
        default: next_ctrl = ctrl;
      endcase
    end
    if (cfg_rd_in) begin
      case (cfg_addr_in)
        `SVD_ADDR_CTRL:     next_rdata = ctrl;
        `SVD_ADDR_STATUS:   next_rdata = {6'h00, ovf, locked};
        `SVD_ADDR_PORT_SEL: next_rdata = {6'h00, psel};
        `SVD_ADDR_PORT_CFG: next_rdata = psel[1] ? pcfg[1] : pcfg[0];
        default:            next_rdata = 8'h00;
      endcase
      if (cfg_addr_in == `SVD_ADDR_STATUS) begin
        next_ovf = 1'b0;
      end
    end
    if (fin.valid && !fin.ready) begin
      next_ovf = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      ctrl          <= `SVD_CTRL_RST;
      psel          <= `SVD_PORT_SEL_RST;
      pcfg          <= '{8'h00, 8'h00};
      cfg_rdata_out <= 8'h00;
      ovf           <= 1'b0;
    end else begin
      ctrl          <= next_ctrl;
      psel          <= next_psel;
      pcfg          <= next_pcfg;
      cfg_rdata_out <= next_rdata;
      ovf           <= next_ovf;
    end
  end

  // display lane engine
  logic [3:0] div_cnt, next_div_cnt;
  logic [2:0] ui,      next_ui;
  logic       active,  next_active;
  svd_sym_t   stage,   next_stage;
  logic       stage_v, next_stage_v;
  logic       tick, period_end, data_ok, data_load, osc_load, lane_load;
  logic       show;
  svd_sym_t   first_sym;
  svd_word_t  lane_word [8];
  svd_word_t  clk_word  [2];

  always_comb begin
    tick       = (div_cnt == 4'(`SVD_BIT_DIV - 1));
    period_end = tick & ((ui == 3'(`SVD_UI_BITS - 1)) | ~active);
    data_ok    = locked & (dual ? (stage_v & fout.valid) : fout.valid);
    data_load  = period_end & data_ok;
    osc_load   = period_end & ~locked & osc_en;
    lane_load  = data_load | osc_load;
    show       = out_en & sleep_sel;
    first_sym  = dual ? stage : fout.data;
    if (!locked) begin
      fout.ready = 1'b1;
    end else if (dual) begin
      fout.ready = ~stage_v | data_load;
    end else begin
      fout.ready = data_load;
    end
    next_div_cnt = tick ? 4'h0 : div_cnt + 4'h1;
    next_active  = active;
    next_ui      = ui;
    if (lane_load) begin
      next_active = 1'b1;
      next_ui     = 3'h0;
    end else if (tick && active) begin
      if (ui == 3'(`SVD_UI_BITS - 1)) begin
        next_active = 1'b0;
      end else begin
        next_ui = ui + 3'h1;
      end
    end
    next_stage   = stage;
    next_stage_v = stage_v;
    if (!locked || data_load) begin
      next_stage_v = 1'b0;
    end else if (dual && !stage_v && fout.valid) begin
      next_stage_v = 1'b1;
      next_stage   = fout.data;
    end
    for (int i = 0; i < `SVD_LANES; i++) begin
      lane_word[i] = (data_load && show) ?
                     first_sym[i*`SVD_UI_BITS +: `SVD_UI_BITS] : '0;
      lane_word[i+`SVD_LANES] = (data_load && show && dual) ?
                     fout.data[i*`SVD_UI_BITS +: `SVD_UI_BITS] : '0;
    end
    clk_word[0] = ((data_load && show) || osc_load) ? `SVD_CLK_PATTERN : '0;
    clk_word[1] = dual ? clk_word[0] : '0;
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      div_cnt <= 4'h0;
      ui      <= 3'h0;
      active  <= 1'b0;
      stage   <= '0;
      stage_v <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      ui      <= next_ui;
      active  <= next_active;
      stage   <= next_stage;
      stage_v <= next_stage_v;
    end
  end

  for (genvar g = 0; g < 2 * `SVD_LANES; g++) begin : g_data
    svd_lane u_lane (
      .clk_in     (clk_in),
      .sys_rst_in (rst),
      .load_in    (lane_load),
      .tick_in    (tick),
      .word_in    (lane_word[g]),
      .bit_out    (lvds_data_out[g])
    );
  end
  for (genvar c = 0; c < 2; c++) begin : g_clk
    svd_lane u_lane (
      .clk_in     (clk_in),
      .sys_rst_in (rst),
      .load_in    (lane_load),
      .tick_in    (tick),
      .word_in    (clk_word[c]),
      .bit_out    (lvds_clk_out[c])
    );
  end

  // output state and bridge drive
  logic fwd_i2c;
  always_ff @(posedge clk_in) begin
    if (rst) begin
      lvds_oe_out    <= 1'b0;
      lock_out       <= 1'b0;
      lock_oe_out    <= 1'b0;
      link_ready_out <= 1'b0;
      fwd_i2c        <= 1'b1;
      i2c_sda_oe_out <= 1'b0;
    end else begin
      lvds_oe_out    <= out_en | ~sleep_sel;
      lock_out       <= locked & sleep_sel;
      lock_oe_out    <= out_en | locked;
      link_ready_out <= fin.ready;
      if (fin.valid) begin
        fwd_i2c <= fin.data[`SVD_FWD_I2C_BIT];
      end
      i2c_sda_oe_out <= locked & ~fwd_i2c & ~busy_s;
    end
  end
  assign i2c_sda_out = 1'b0;

  // back-channel frames
  function automatic logic [3:0] svd_crc4(input logic [5:0] d);
    logic [3:0] c;
    logic       fb;
    c = 4'h0;
    for (int i = 5; i >= 0; i--) begin
      fb = c[3] ^ d[i];
      c  = {c[2:0], 1'b0} ^ (fb ? `SVD_CRC_POLY : 4'h0);
    end
    return c;
  endfunction : svd_crc4

  svd_bc_state_t bc_st, next_bc_st;
  logic [11:0] bc_shift, next_bc_shift;
  logic [3:0]  bc_idx,   next_bc_idx;
  logic [4:0]  bc_cnt,   next_bc_cnt;
  logic [4:0]  bc_per;
  logic [5:0]  bc_pay;

  always_comb begin
    bc_per = strap_fast ? 5'(`SVD_BC_FAST_CYC) : 5'(`SVD_BC_SLOW_CYC);
    bc_pay = {busy_s, sda_s, gpio_s};
    next_bc_st    = bc_st;
    next_bc_shift = bc_shift;
    next_bc_idx   = bc_idx;
    next_bc_cnt   = bc_cnt;
    case (bc_st)
      SVD_BC_IDLE: begin
        if (strap_taken) begin
          next_bc_st    = SVD_BC_SEND;
          next_bc_shift = {1'b1, svd_crc4(bc_pay), bc_pay, 1'b0};
          next_bc_idx   = 4'h0;
          next_bc_cnt   = 5'h00;
        end
      end
      SVD_BC_SEND: begin
        if (bc_cnt == bc_per - 5'h01) begin
          next_bc_cnt   = 5'h00;
          next_bc_shift = {1'b1, bc_shift[11:1]};
          if (bc_idx == 4'(`SVD_BC_FRAME_BITS - 1)) begin
            next_bc_st = SVD_BC_IDLE;
          end else begin
            next_bc_idx = bc_idx + 4'h1;
          end
        end else begin
          next_bc_cnt = bc_cnt + 5'h01;
        end
      end
      default: next_bc_st = SVD_BC_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      bc_st    <= SVD_BC_IDLE;
      bc_shift <= 12'hFFF;
      bc_idx   <= 4'h0;
      bc_cnt   <= 5'h00;
    end else begin
      bc_st    <= next_bc_st;
      bc_shift <= next_bc_shift;
      bc_idx   <= next_bc_idx;
      bc_cnt   <= next_bc_cnt;
    end
  end
  assign back_chan_out = bc_shift[0];
endmodule : svd_core

// [hw/svd_fifo.sv]
/*
  Flip-flop FIFO with valid/ready on both sides, honest full and empty.
  Assumes a synchronous active-high reset on the same clock as both sides.
*/
`timescale 1ns/1ps
module svd_fifo #(
  parameter int W     = 35,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // streams
  svd_stream_if.snk in_s,
  svd_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem      [DEPTH];
  logic [W-1:0] next_mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr;
  logic [AW-1:0] rd_ptr, next_rd_ptr;
  logic [AW:0]   count,  next_count;
  logic          push, pop;

  assign in_s.ready  = (count != (AW+1)'(DEPTH));
  assign out_s.valid = (count != '0);
  assign out_s.data  = mem[rd_ptr];

  always_comb begin
    push        = in_s.valid & in_s.ready;
    pop         = out_s.valid & out_s.ready;
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_mem[wr_ptr] = in_s.data;
      next_wr_ptr      = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    mem <= next_mem;
    if (sys_rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end
endmodule : svd_fifo

// [hw/svd_lane.sv]
/*
  One seven-bit output lane: loads a word, sends bit 0 first, one bit per
  tick. Assumes load_in only comes together with tick_in.
*/
`timescale 1ns/1ps
`include "svd_params.svh"
module svd_lane
  import svd_pkg::*;
(
  // clock and reset
  input  wire logic      clk_in,
  input  wire logic      sys_rst_in,
  // control
  input  wire logic      load_in,
  input  wire logic      tick_in,
  input  wire svd_word_t word_in,
  // serial bit
  output logic           bit_out
);
  svd_word_t shreg, next_shreg;
  logic      next_bit;

  always_comb begin
    next_shreg = shreg;
    next_bit   = bit_out;
    if (load_in) begin
      next_bit   = word_in[0];
      next_shreg = {1'b0, word_in[`SVD_UI_BITS-1:1]};
    end else if (tick_in) begin
      next_bit   = shreg[0];
      next_shreg = {1'b0, shreg[`SVD_UI_BITS-1:1]};
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      shreg   <= '0;
      bit_out <= 1'b0;
    end else begin
      shreg   <= next_shreg;
      bit_out <= next_bit;
    end
  end
endmodule : svd_lane

// [pkg/svd_params.svh]
/*
  Constants of the serial video deserializer core: symbol and lane shape,
  timing counts, configuration addresses, field positions, reset values.
  Assumes a 100 MHz core clock; included by the package and the core and lane design files.
*/
`ifndef SVD_PARAMS_SVH
`define SVD_PARAMS_SVH

`define SVD_SYM_W          35
`define SVD_UI_BITS        7
`define SVD_LANES          4
`define SVD_FIFO_DEPTH     4
`define SVD_CLK_MHZ        100
`define SVD_CLK_PERIOD_NS  10
`define SVD_LOSS_TIME_NS   1000
`define SVD_LOSS_CYCLES    (`SVD_LOSS_TIME_NS / `SVD_CLK_PERIOD_NS)
`define SVD_LOCK_EDGES     16
`define SVD_BIT_DIV        2
`define SVD_CLK_PATTERN    7'h63
`define SVD_BC_SLOW_MBPS   5
`define SVD_BC_FAST_MBPS   20
`define SVD_BC_SLOW_CYC    (`SVD_CLK_MHZ / `SVD_BC_SLOW_MBPS)
`define SVD_BC_FAST_CYC    (`SVD_CLK_MHZ / `SVD_BC_FAST_MBPS)
`define SVD_BC_FRAME_BITS  12
`define SVD_CRC_POLY       4'h3
`define SVD_FWD_I2C_BIT    34
`define SVD_ADDR_CTRL      8'h02
`define SVD_ADDR_STATUS    8'h1C
`define SVD_ADDR_PORT_SEL  8'h34
`define SVD_ADDR_PORT_CFG  8'h40
`define SVD_CTRL_OE_BIT    7
`define SVD_CTRL_OSC_BIT   5
`define SVD_CTRL_SLEEP_BIT 4
`define SVD_CTRL_RST       8'h90
`define SVD_PORT_SEL_RST   2'h1

`endif

// [pkg/svd_pkg.sv]
/*
  Types of the serial video deserializer core.
  Assumes svd_params.svh is on the include path.
*/
`include "svd_params.svh"
package svd_pkg;
  typedef logic [`SVD_SYM_W-1:0]   svd_sym_t;
  typedef logic [`SVD_UI_BITS-1:0] svd_word_t;
  typedef enum logic [1:0] {
    SVD_LOSS   = 2'h0,
    SVD_ACQ    = 2'h1,
    SVD_LOCKED = 2'h3
  } svd_lock_state_t;
  typedef enum logic {
    SVD_BC_IDLE = 1'h0,
    SVD_BC_SEND = 1'h1
  } svd_bc_state_t;
endpackage : svd_pkg

// [pkg/svd_stream_if.sv]
/*
  Valid/ready word stream between the core and its symbol buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface svd_stream_if #(parameter int W = 35);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : svd_stream_if

// [tb/svd_core_monitor.sv]
/*
  Checker of the deserializer core's port behaviour.
  Assumes it is bound into svd_core and runs on clk_in.
*/
`timescale 1ns/1ps
module svd_core_monitor (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       sys_rst_in,
  input wire logic       power_down_n_in,
  // link and bridge pins
  input wire logic       link_clk_in,
  input wire logic       local_master_busy_in,
  // configuration port
  input wire logic       cfg_wr_in,
  input wire logic       cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in,
  input wire logic [7:0] cfg_rdata_out,
  // outputs
  input wire logic [7:0] lvds_data_out,
  input wire logic [1:0] lvds_clk_out,
  input wire logic       lvds_oe_out,
  input wire logic       lock_out,
  input wire logic       lock_oe_out,
  input wire logic       i2c_sda_oe_out,
  input wire logic       back_chan_out
);
  logic [7:0] ctrl, p0, p1, since, idle;
  logic [1:0] psel, v;
  logic       lc_q;
  wire        rst = sys_rst_in | !power_down_n_in;
  wire  [8:0] dup = psel[1] ? {v[1], p1} : {v[0], p0};
  // shadow of settings, link idle time, time since control write
  always_ff @(posedge clk_in) begin
    lc_q <= link_clk_in;
    if (rst) begin
      ctrl <= 8'h90;
      psel <= 2'h1;
      v <= 2'h0;
      since <= 8'h00;
      idle <= 8'h00;
    end else begin
      since <= since + 8'(since != 8'hFF);
      idle <= (link_clk_in != lc_q) ? 8'h00 : idle + 8'(idle != 8'hFF);
      if (cfg_wr_in && cfg_addr_in == 8'h02) begin
        ctrl <= cfg_wdata_in;
        since <= 8'h00;
      end
      if (cfg_wr_in && cfg_addr_in == 8'h34) psel <= cfg_wdata_in[1:0];
      if (cfg_wr_in && cfg_addr_in == 8'h40) begin
        if (psel[0]) p0 <= cfg_wdata_in;
        if (psel[1]) p1 <= cfg_wdata_in;
        v <= v | psel;
      end
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst);
  chk_ctrl_read: assert property (
    cfg_rd_in && cfg_addr_in == 8'h02 |=> cfg_rdata_out == $past(ctrl))
    else $error("control readback wrong");
  chk_psel_read: assert property (
    cfg_rd_in && cfg_addr_in == 8'h34 |=> cfg_rdata_out[1:0] == $past(psel))
    else $error("port select readback wrong");
  chk_dup_read: assert property (
    cfg_rd_in && cfg_addr_in == 8'h40 && dup[8]
    |=> cfg_rdata_out == $past(dup[7:0]))
    else $error("port copy readback wrong");
  chk_lane_enable: assert property (
    since > 8'h03 |-> lvds_oe_out == (ctrl[7] | !ctrl[4]))
    else $error("lane enable wrong");
  chk_lanes_quiet: assert property (
    since > 8'h03 && !(ctrl[7] && ctrl[4]) |-> lvds_data_out == 8'h00)
    else $error("lanes not quiet");
  chk_lock_wait: assert property (
    $fell(rst) |=> !lock_out [*8])
    else $error("lock too early");
  chk_lock_drive: assert property (
    lock_out |-> lock_oe_out)
    else $error("lock high but not driven");
  chk_loss_drop: assert property (
    idle > 8'h6E |-> !lock_out)
    else $error("lock held on lost link");
  chk_osc_fallback: assert property (
    idle > 8'hC8 && ctrl[5] && ctrl[7] && ctrl[4] && since > 8'h03
    |-> ##[1:16] $changed(lvds_clk_out[0]))
    else $error("no oscillator clock");
  chk_clk_low: assert property (
    $fell(lvds_clk_out[0]) && since > 8'h10 |-> !lvds_clk_out[0] [*6])
    else $error("clock lane low run short");
  chk_bc_bit: assert property (
    $fell(back_chan_out) |-> !back_chan_out [*5])
    else $error("back channel bit short");
  chk_i2c_busy: assert property (
    local_master_busy_in [*4] |-> !i2c_sda_oe_out)
    else $error("bridge drives over local master");
  cov_lock: cover property ($rose(lock_out));
  cov_loss: cover property ($fell(lock_out));
  cov_both: cover property (cfg_rd_in && cfg_addr_in == 8'h40 && &psel);
endmodule : svd_core_monitor

bind svd_core svd_core_monitor svd_core_monitor_inst (.*);

// [tb/svd_ser_model.sv]
/*
  Serializer stand-in: drives the link clock and one symbol per clock.
  Assumes the bench raises run_in while a burst is wanted.
*/
`timescale 1ns/1ps
module svd_ser_model
  import svd_pkg::*;
(
  // control
  input  wire logic run_in,
  input  wire logic sda_low_in,
  // link
  output logic      link_clk_out,
  output svd_sym_t  sym_out
);
  int n;
  initial begin
    link_clk_out = 1'b0;
    sym_out = '0;
    n = 0;
    forever if (run_in) begin
      // one symbol a clock, data steps by 9E37 per symbol, no training
      sym_out = {~sda_low_in, 34'(n * 32'h9E37)};
      #31.25 link_clk_out = 1'b1;
      #62.5 link_clk_out = 1'b0;
      #31.25 n++;
    end else begin
      // clock stands still, stale symbol scrambled
      sym_out = ~sym_out;
      #10;
    end
  end
endmodule : svd_ser_model

// [tb/tb.sv]
/*
  Self-checking bench of the deserializer core.
  Assumes the serializer model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module tb
  import svd_pkg::*;
;
  logic       clk_in, sys_rst_in, power_down_n_in, run, sda_low, ext_pull;
  logic       mode_strap_one_in, dual_output_in, cfg_wr_in, cfg_rd_in;
  logic       local_master_busy_in, i2c_sda_in, link_clk_in, lvds_oe_out;
  logic       link_ready_out, lock_out, lock_oe_out, i2c_sda_oe_out;
  logic       back_chan_out;
  logic [7:0] cfg_addr_in, cfg_wdata_in, cfg_rdata_out, lvds_data_out;
  logic [3:0] gpio_in;
  logic [1:0] lvds_clk_out;
  svd_sym_t   link_symbol_in;
  logic [15:0][9:0] h;
  logic [7:0] cv [4] = '{8'h00, 8'h10, 8'h80, 8'h90};
  int         checked, err_total, i, n;

  svd_ser_model svd_ser_model_inst (.run_in(run), .sda_low_in(sda_low),
    .link_clk_out(link_clk_in), .sym_out(link_symbol_in));
  svd_core svd_core_inst (.clk_in, .sys_rst_in, .power_down_n_in,
    .link_clk_in, .link_symbol_in, .link_ready_out, .mode_strap_one_in,
    .dual_output_in, .cfg_wr_in, .cfg_rd_in, .cfg_addr_in, .cfg_wdata_in,
    .cfg_rdata_out, .lvds_data_out, .lvds_clk_out, .lvds_oe_out, .lock_out,
    .lock_oe_out, .gpio_in, .i2c_sda_in, .local_master_busy_in,
    .i2c_sda_out(), .i2c_sda_oe_out, .back_chan_out);

  always #5 clk_in = ~clk_in;
  // open-drain data line: low if the core or the other master pulls
  assign i2c_sda_in = !(i2c_sda_oe_out | ext_pull);
  always @(posedge clk_in) h <= {h[14:0], lvds_clk_out, lvds_data_out};

  task cyc(int k);
    repeat (k) @(negedge clk_in);
  endtask : cyc
  task chk(string nm, logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_in);
    cfg_wr_in <= 1'b1;
    cfg_addr_in <= a;
    cfg_wdata_in <= d;
    @(posedge clk_in);
    cfg_wr_in <= 1'b0;
  endtask : wr
  task rc(logic [7:0] a, logic [7:0] e);
    @(posedge clk_in);
    cfg_rd_in <= 1'b1;
    cfg_addr_in <= a;
    @(posedge clk_in);
    cfg_rd_in <= 1'b0;
    cyc(1);
    chk("rdata", 32'(cfg_rdata_out), 32'(e));
  endtask : rc
  task frame(int bc, logic s, logic [3:0] crc);
    logic [11:0] f;
    for (i = 0; i < 99 && back_chan_out !== 1'b0; i++) cyc(1);
    cyc(bc / 2);
    for (i = 0; i < 12; i++) begin
      f[i] = back_chan_out;
      cyc(bc);
    end
    chk("frame", 32'(f),
        32'({1'b1, crc, local_master_busy_in, s, gpio_in, 1'b0}));
  endtask : frame
  task lanes;
    logic [27:0] a, b;
    for (i = 0; i < 99; i++) begin
      if ({h[7][8], h[6][8], h[1][8], h[0][8]} === 4'b1001) break;
      cyc(1);
    end
    cyc(2);
    for (i = 0; i < 28; i++) begin
      a[i] = h[(6 - i % 7) * 2][i / 7];
      b[i] = h[(6 - i % 7) * 2][4 + i / 7];
    end
    chk("lanes", 32'(b), 32'(a + 28'h9E37));
  endtask : lanes
  task stop_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  initial begin
    #100000;
    err_total++;
    stop_test();
  end

  initial begin
    clk_in = 1'b0;
    sys_rst_in = 1'b1;
    power_down_n_in = 1'b1;
    run = 1'b0;
    sda_low = 1'b0;
    ext_pull = 1'b1;
    mode_strap_one_in = 1'b0;
    dual_output_in = 1'b0;
    cfg_wr_in = 1'b0;
    cfg_rd_in = 1'b0;
    cfg_addr_in = 8'h00;
    cfg_wdata_in = 8'h00;
    gpio_in = 4'hA;
    local_master_busy_in = 1'b0;
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    frame(20, 1'b0, 4'hD);
    rc(8'h02, 8'h90);
    rc(8'h34, 8'h01);
    rc(8'h77, 8'h00);
    wr(8'h40, 8'hAA);
    wr(8'h34, 8'h02);
    wr(8'h40, 8'h55);
    rc(8'h40, 8'h55);
    wr(8'h34, 8'h01);
    rc(8'h40, 8'hAA);
    wr(8'h34, 8'h03);
    rc(8'h40, 8'h55);
    wr(8'h40, 8'h3C);
    wr(8'h34, 8'h01);
    rc(8'h40, 8'h3C);
    for (n = 0; n < 4; n++) begin
      wr(8'h02, cv[n]);
      cyc(20);
      chk("lane_oe", 32'(lvds_oe_out), 32'(cv[n][7] | !cv[n][4]));
      chk("lock_oe", 32'(lock_oe_out), 32'(cv[n][7]));
    end
    @(posedge clk_in) run <= 1'b1;
    for (i = 0; i < 600 && lock_out !== 1'b1; i++) cyc(1);
    chk("lock", 32'(lock_out), 1);
    for (i = 0; i < 1500 && link_ready_out !== 1'b0; i++) cyc(1);
    chk("full", 32'(link_ready_out), 0);
    cyc(300);
    @(posedge clk_in) run <= 1'b0;
    cyc(20);
    rc(8'h1C, 8'h03);
    rc(8'h1C, 8'h01);
    for (i = 0; i < 90 && link_ready_out !== 1'b1; i++) cyc(1);
    chk("drain", 32'(link_ready_out), 1);
    for (i = 0; i < 200 && lock_out !== 1'b0; i++) cyc(1);
    chk("loss", 32'(lock_out), 0);
    wr(8'h02, 8'hB0);
    n = 0;
    for (i = 0; i < 40; i++) begin
      cyc(1);
      n += int'(lvds_clk_out[0] !== h[0][8]);
    end
    chk("osc", 32'(n > 0), 1);
    wr(8'h02, 8'h90);
    @(posedge clk_in);
    power_down_n_in <= 1'b0;
    mode_strap_one_in <= 1'b1;
    dual_output_in <= 1'b1;
    ext_pull <= 1'b0;
    sda_low <= 1'b1;
    repeat (4) @(posedge clk_in);
    power_down_n_in <= 1'b1;
    frame(5, 1'b1, 4'h8);
    @(posedge clk_in) run <= 1'b1;
    for (i = 0; i < 600 && lock_out !== 1'b1; i++) cyc(1);
    chk("relock", 32'(lock_out), 1);
    lanes();
    lanes();
    chk("bridge", 32'(i2c_sda_oe_out), 1);
    @(posedge clk_in) local_master_busy_in <= 1'b1;
    cyc(5);
    chk("arbitrate", 32'(i2c_sda_oe_out), 0);
    stop_test();
  end
endmodule : tb
